// ==== hdl/tic_pkg.sv ====
// Purpose: shared constants of the timer input capture unit
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes: offsets are byte addresses, all multiples of four
`default_nettype none
package tic_pkg;
    // bus geometry, counter width and input count
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_INPUTS = 4;
    // register offsets
    localparam logic [5:0] OFF_MODE = 6'h00;
    localparam logic [5:0] OFF_INT0 = 6'h04;
    localparam logic [5:0] OFF_INT1 = 6'h08;
    localparam logic [5:0] OFF_INT2 = 6'h0c;
    localparam logic [5:0] OFF_INT3 = 6'h10;
    localparam logic [5:0] OFF_DUAL = 6'h14;
    localparam logic [5:0] OFF_CAP = 6'h18;
    localparam logic [5:0] OFF_STAT = 6'h1c;
    localparam logic [5:0] OFF_MASK = 6'h20;
    // timer_mode_reg_two fields
    localparam int MODE_SRC_LSB = 0;
    localparam int MODE_EN_BIT = 2;
    localparam int MODE_CLR_BIT = 5;
    localparam int MODE_EDGE_BIT = 7;
    // ext_int_ctrl_reg field
    localparam int POL_BIT = 5;
    // dual_edge_int_reg fields
    localparam int DUAL0_BIT = 0;
    localparam int DUAL1_BIT = 1;
    // status and mask layout
    localparam int STAT_CAP_BIT = 0;
    localparam int STAT_INT_LSB = 1;
    localparam int STAT_W = 5;
    // values after reset
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [3:0] RST_POL = 4'h0;
    localparam logic [1:0] RST_DUAL = 2'h0;
    localparam logic [4:0] RST_STAT = 5'h00;
    localparam logic [4:0] RST_MASK = 5'h00;
    localparam logic [15:0] RST_CAP = 16'h0000;
endpackage
`default_nettype wire

// ==== hdl/tic_edge_det.sv ====
// Purpose: one external interrupt input, synchronised and edge detected
// Assumes: pin may be asynchronous; two flip-flops resync it
// Notes: all outputs are one-cycle pulses from flip-flops
`default_nettype none
module tic_edge_det #(
    parameter bit HAS_DUAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // pin and settings
    input wire logic i_pin,
    input wire logic i_pol,
    input wire logic i_dual,
    // event pulses
    output logic o_int_q,
    output logic o_single_q,
    output logic o_any_q
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic pol_prev_q;
    logic act_now;
    logic act_prev;
    logic single_d;
    logic any_d;

    // two-stage sync; meta_q feeds only sync_q
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            pol_prev_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
            pol_prev_q <= i_pol;
        end
    end

    // active level folds polarity in, so a polarity flip onto the live level fires
    assign act_now = i_pol ? sync_q : ~sync_q;
    assign act_prev = pol_prev_q ? prev_q : ~prev_q;
    assign single_d = act_now & ~act_prev;
    assign any_d = sync_q ^ prev_q;

    // registered event pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_single_q <= 1'b0;
            o_any_q <= 1'b0;
            o_int_q <= 1'b0;
        end else begin
            o_single_q <= single_d;
            o_any_q <= any_d;
            o_int_q <= (HAS_DUAL && i_dual) ? any_d : single_d;
        end
    end

    a_pol_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        single_d |=> o_single_q) else $error("single edge pulse missing");
    a_dual_int: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (HAS_DUAL && i_dual && any_d) |=> o_int_q) else $error("dual edge interrupt missing");
    a_no_dual: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!HAS_DUAL && !single_d) |=> !o_int_q) else $error("interrupt without selected edge");
endmodule
`default_nettype wire

// ==== hdl/tic_cap_reg.sv ====
// Purpose: 16-bit capture register loaded from the counter
// Assumes: trigger is a one-cycle pulse in the clock domain
// Notes: written data never reaches this register
`default_nettype none
module tic_cap_reg #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // trigger and counter
    input wire logic i_trig,
    input wire logic [CNT_W-1:0] i_count,
    // captured value
    output logic [CNT_W-1:0] o_value
);
    // counter taken at the edge closing the trigger pulse; no overrun guard
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_value <= CNT_W'(tic_pkg::RST_CAP);
        end else if (i_trig) begin
            o_value <= i_count;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/tic_top.sv ====
// Purpose: input capture unit of a 16-bit timer with avalon-mm registers
// Assumes: counter value arrives on i_count in the i_sys_clk domain
// Notes: counter, compare and pwm logic live elsewhere
//
// Implementation choices: the address map and the Avalon-MM slave port.
`default_nettype none
// Overview of operation
// - capture counter on external or write trigger
// - two-bit field picks which external input
// - edge mode one: only polarity-chosen edge
// - edge mode zero: capture every rise and fall
// - polarity bit five: one rising, zero falling
// - inputs 0,1 have dual-edge interrupt select
// - interrupt edge follows own interrupt settings
// - polarity flip onto live level fires event
// - counter value taken at trigger pulse end
// - new capture overwrites, no overrun flag
// - external triggering disabled after reset
// - write to capture register with byte lane 0 or 1 enabled triggers
// - written data is never stored
// - write trigger ignores enable, always active
module tic_top (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // external interrupt pins and counter
    input wire logic [3:0] i_ext_int,
    input wire logic [15:0] i_count,
    // avalon-mm slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // outputs to the timer and interrupt controller
    output logic [15:0] o_capture,
    output logic o_counter_clear_sel,
    output logic [3:0] o_ext_int_req,
    output logic o_irq
);
    logic rst_meta_q;
    logic rst_n_q;
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [7:0] mode_q;
    logic [3:0] pol_q;
    logic [1:0] dual_q;
    logic [4:0] stat_q;
    logic [4:0] mask_q;
    logic irq_q;
    logic clr_sel_q;
    logic [3:0] int_pulse;
    logic [3:0] single_pulse;
    logic [3:0] any_pulse;
    logic [3:0] int_req_q;
    logic [15:0] cap_value;
    logic [1:0] src_sel;
    logic edge_mode;
    logic ext_en;
    logic wr_acc;
    logic rd_take;
    logic sw_trig;
    logic ext_trig;
    logic trig;
    logic [4:0] stat_set;
    logic [4:0] stat_clr;
    logic [31:0] rd_mux;

    // address match, used by both read and write decode
    function automatic logic f_hit(input logic [5:0] addr, input logic [5:0] off);
        f_hit = (addr == off);
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // one wait cycle per access; answer at the second edge
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            waitreq_q <= 1'b1;
        end else if ((i_avs_read || i_avs_write) && waitreq_q) begin
            waitreq_q <= 1'b0;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    assign wr_acc = i_avs_write && !waitreq_q;
    assign rd_take = i_avs_read && waitreq_q;

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (f_hit(i_avs_address, tic_pkg::OFF_MODE)) begin
            rd_mux[7:0] = mode_q;
        end else if (f_hit(i_avs_address, tic_pkg::OFF_INT0)) begin
            rd_mux[tic_pkg::POL_BIT] = pol_q[0];
        end else if (f_hit(i_avs_address, tic_pkg::OFF_INT1)) begin
            rd_mux[tic_pkg::POL_BIT] = pol_q[1];
        end else if (f_hit(i_avs_address, tic_pkg::OFF_INT2)) begin
            rd_mux[tic_pkg::POL_BIT] = pol_q[2];
        end else if (f_hit(i_avs_address, tic_pkg::OFF_INT3)) begin
            rd_mux[tic_pkg::POL_BIT] = pol_q[3];
        end else if (f_hit(i_avs_address, tic_pkg::OFF_DUAL)) begin
            rd_mux[1:0] = dual_q;
        end else if (f_hit(i_avs_address, tic_pkg::OFF_CAP)) begin
            rd_mux[15:0] = cap_value;
        end else if (f_hit(i_avs_address, tic_pkg::OFF_STAT)) begin
            rd_mux[4:0] = stat_q;
        end else if (f_hit(i_avs_address, tic_pkg::OFF_MASK)) begin
            rd_mux[4:0] = mask_q;
        end
    end

    // read data latched when the access is first seen, held to the answer
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    // mode register; enable clear after reset keeps pins from capturing
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= tic_pkg::RST_MODE;
        end else if (wr_acc && i_avs_byteenable[0] && f_hit(i_avs_address, tic_pkg::OFF_MODE)) begin
            mode_q <= i_avs_writedata[7:0];
        end
    end

    // edge polarity per input, only bit five is kept
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pol_q <= tic_pkg::RST_POL;
        end else if (wr_acc && i_avs_byteenable[0]) begin
            if (f_hit(i_avs_address, tic_pkg::OFF_INT0)) begin
                pol_q[0] <= i_avs_writedata[tic_pkg::POL_BIT];
            end
            if (f_hit(i_avs_address, tic_pkg::OFF_INT1)) begin
                pol_q[1] <= i_avs_writedata[tic_pkg::POL_BIT];
            end
            if (f_hit(i_avs_address, tic_pkg::OFF_INT2)) begin
                pol_q[2] <= i_avs_writedata[tic_pkg::POL_BIT];
            end
            if (f_hit(i_avs_address, tic_pkg::OFF_INT3)) begin
                pol_q[3] <= i_avs_writedata[tic_pkg::POL_BIT];
            end
        end
    end

    // dual-edge interrupt selects exist for inputs 0 and 1 only
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dual_q <= tic_pkg::RST_DUAL;
        end else if (wr_acc && i_avs_byteenable[0] && f_hit(i_avs_address, tic_pkg::OFF_DUAL)) begin
            dual_q[0] <= i_avs_writedata[tic_pkg::DUAL0_BIT];
            dual_q[1] <= i_avs_writedata[tic_pkg::DUAL1_BIT];
        end
    end

    // per-input edge detectors; inputs 2 and 3 lack the dual option
    for (genvar g = 0; g < tic_pkg::NUM_INPUTS; g++) begin : g_in
        tic_edge_det #(
            .HAS_DUAL(g < 2)
        ) u_edge (
            .i_clk(i_sys_clk),
            .i_rst_n(rst_n_q),
            .i_pin(i_ext_int[g]),
            .i_pol(pol_q[g]),
            .i_dual((g < 2) ? dual_q[g % 2] : 1'b0),
            .o_int_q(int_pulse[g]),
            .o_single_q(single_pulse[g]),
            .o_any_q(any_pulse[g])
        );
    end

    assign src_sel = mode_q[tic_pkg::MODE_SRC_LSB +: 2];
    assign edge_mode = mode_q[tic_pkg::MODE_EDGE_BIT];
    assign ext_en = mode_q[tic_pkg::MODE_EN_BIT];

    // capture edge is independent of the interrupt edge
    assign ext_trig = ext_en && (edge_mode ? single_pulse[src_sel] : any_pulse[src_sel]);
    // any byte write to lanes 0 or 1 fires; data is dropped
    assign sw_trig = wr_acc && (|i_avs_byteenable[1:0]) && f_hit(i_avs_address, tic_pkg::OFF_CAP);
    assign trig = ext_trig || sw_trig;

    // capture register; only the counter ever reaches it
    tic_cap_reg #(
        .CNT_W(tic_pkg::CNT_W)
    ) u_cap (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_q),
        .i_trig(trig),
        .i_count(i_count),
        .o_value(cap_value)
    );

    // sticky events: capture and the four interrupt requests
    assign stat_set = {int_pulse, trig};
    assign stat_clr = (wr_acc && i_avs_byteenable[0] && f_hit(i_avs_address, tic_pkg::OFF_STAT))
        ? i_avs_writedata[4:0] : 5'h00;

    // set beats a write-one-to-clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= tic_pkg::RST_STAT;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= tic_pkg::RST_MASK;
        end else if (wr_acc && i_avs_byteenable[0] && f_hit(i_avs_address, tic_pkg::OFF_MASK)) begin
            mask_q <= i_avs_writedata[4:0];
        end
    end

    // registered outputs; irq lags the status by one cycle
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
            clr_sel_q <= 1'b0;
            int_req_q <= 4'h0;
        end else begin
            irq_q <= |(stat_q & mask_q);
            clr_sel_q <= mode_q[tic_pkg::MODE_CLR_BIT];
            int_req_q <= int_pulse;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = waitreq_q;
    assign o_capture = cap_value;
    assign o_counter_clear_sel = clr_sel_q;
    assign o_ext_int_req = int_req_q;
    assign o_irq = irq_q;

    // checks on trigger selection and capture value
    a_cap_value: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        trig |=> (cap_value == $past(i_count))) else $error("capture value not the counter");
    a_cap_stable: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !trig |=> $stable(cap_value)) else $error("capture changed without trigger");
    a_sw_trigger: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (i_avs_write && !o_avs_waitrequest && i_avs_address == tic_pkg::OFF_CAP
         && i_avs_byteenable[0]) |-> trig) else $error("write did not trigger capture");
    a_ext_disabled: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (!mode_q[tic_pkg::MODE_EN_BIT] && !sw_trig) |-> !trig) else $error("capture while disabled");
    a_both_edges: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (ext_en && !edge_mode && any_pulse[src_sel]) |-> trig) else $error("both-edge capture missed");
    a_single_only: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (edge_mode && !single_pulse[src_sel] && !sw_trig) |-> !trig) else $error("capture on wrong edge");
    a_src_select: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        ext_trig |-> (any_pulse[src_sel] || single_pulse[src_sel])) else $error("trigger from wrong input");
    a_overwrite: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        trig ##1 trig |=> (cap_value == $past(i_count))) else $error("second capture not stored");
    a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (|(stat_q & mask_q)) |=> o_irq) else $error("irq not raised");
    a_wait_answer: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("no answer after one wait cycle");

    // settings change only at an accepted write, so pins stay idle until enabled
    a_mode_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (wr_acc && i_avs_byteenable[0] && i_avs_address == tic_pkg::OFF_MODE) |=> (mode_q == $past(i_avs_writedata[7:0])))
        else $error("mode write lost");
    a_mode_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !wr_acc |=> $stable(mode_q))
        else $error("mode changed without write");
    a_pol_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (wr_acc && i_avs_byteenable[0] && i_avs_address == tic_pkg::OFF_INT0) |=> (pol_q[0] == $past(i_avs_writedata[5])))
        else $error("polarity write lost");
    a_pol_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !wr_acc |=> $stable(pol_q))
        else $error("polarity changed without write");
    a_dual_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (wr_acc && i_avs_byteenable[0] && i_avs_address == tic_pkg::OFF_DUAL) |=> (dual_q == $past(i_avs_writedata[1:0])))
        else $error("dual select write lost");
    a_dual_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !wr_acc |=> $stable(dual_q))
        else $error("dual select changed without write");
    a_data_dropped: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (sw_trig && i_avs_writedata[15:0] != i_count) |=> (cap_value != $past(i_avs_writedata[15:0])))
        else $error("written data reached capture");

    // status bits are sticky and the interrupt line trails them by one cycle
    a_cap_sticky: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        trig |=> stat_q[tic_pkg::STAT_CAP_BIT])
        else $error("capture status not set");
    a_cap_kept: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        (stat_q[0] && !stat_clr[0]) |=> stat_q[0])
        else $error("capture status lost");
    a_irq_low: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !(|(stat_q & mask_q)) |=> !o_irq)
        else $error("irq without unmasked status");
    a_int_status: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        int_pulse[0] |=> stat_q[tic_pkg::STAT_INT_LSB])
        else $error("interrupt status not set");
    a_req_follow: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        1'b1 |=> (o_ext_int_req == $past(int_pulse)))
        else $error("request pulse mismatch");

    // bus answer lasts one cycle; read data only moves on a new read
    a_wait_once: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer held too long");
    a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        !rd_take |=> $stable(o_avs_readdata))
        else $error("read data moved");
    a_clr_follow: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
        1'b1 |=> (o_counter_clear_sel == $past(mode_q[tic_pkg::MODE_CLR_BIT])))
        else $error("clear select mismatch");

    c_sw_capture: cover property (@(posedge i_sys_clk) disable iff (!rst_n_q) sw_trig);
    c_ext_both: cover property (@(posedge i_sys_clk) disable iff (!rst_n_q) ext_trig && !edge_mode);
    c_ext_single: cover property (@(posedge i_sys_clk) disable iff (!rst_n_q) ext_trig && edge_mode);
    c_irq: cover property (@(posedge i_sys_clk) disable iff (!rst_n_q) $rose(o_irq));
    c_int_req: cover property (@(posedge i_sys_clk) disable iff (!rst_n_q) |o_ext_int_req);
endmodule
`default_nettype wire

// ==== sim/tic_pin_model.sv ====
// Purpose: far-side model of the external interrupt pins and the binary counter
// Assumes: pins and counter change only right after a rising clock edge
// Notes: counter can be frozen so edge captures have an exact expected value
`default_nettype none
module tic_pin_model (
    // clock
    input wire logic i_clk,
    // pins and counter towards the capture unit
    output logic [3:0] o_pins,
    output logic [15:0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pins_q = 4'h0;
    logic [15:0] count_q = 16'h0000;
    logic run_q = 1'b0;
    assign o_pins = pins_q;
    assign o_count = count_q;
    // up counter while run_q is set, over the full 16-bit range, wraps to zero
    always @(posedge i_clk) begin
        if (run_q) begin
            count_q <= count_q + 16'h0001;
        end
    end
    // stop first, load one edge later, so no two writes share a time step
    task automatic set_count(input logic [15:0] v);
        @(posedge i_clk);
        run_q <= 1'b0;
        @(posedge i_clk);
        count_q <= v;
    endtask
    task automatic go();
        @(posedge i_clk);
        run_q <= 1'b1;
    endtask
    // pins are driven levels, no pull needed
    task automatic set_pin(input int n, input logic v);
        @(posedge i_clk);
        pins_q[n] <= v;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench of the timer input capture unit
// Assumes: one access costs two cycles, pin edge shows within four cycles
// Notes: waits after pin changes are fixed at six cycles for margin
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [5:0] i_avs_address = 6'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic [3:0] pins;
    logic [15:0] count;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [15:0] o_capture;
    logic o_counter_clear_sel;
    logic [3:0] o_ext_int_req;
    logic o_irq;
    int mismatches = 0;
    int checked = 0;
    int req_seen = 0;
    logic [31:0] v;
    logic [15:0] c;
    // 50 MHz
    always #10 i_sys_clk = ~i_sys_clk;
    // request pulses last one cycle, so they are tallied as they pass
    always @(posedge i_sys_clk) req_seen <= req_seen + $countones(o_ext_int_req);
    tic_pin_model pm (.i_clk(i_sys_clk), .o_pins(pins), .o_count(count));
    tic_top dut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ext_int(pins), .i_count(count),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .o_capture(o_capture), .o_counter_clear_sel(o_counter_clear_sel),
        .o_ext_int_req(o_ext_int_req), .o_irq(o_irq)
    );
    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // one access; request held until waitrequest is sampled low, count sampled there
    task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rd, output logic [15:0] cnt);
        int n;
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge i_sys_clk);
            if (o_avs_waitrequest === 1'b0) break;
        end
        rd = o_avs_readdata;
        cnt = count;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (n == 20) begin
            mismatches++;
            $display("[ERR] waitrequest expected 0 seen 1");
            results();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        av(1'b1, a, d, 4'h1, r, c);
    endtask
    task automatic rd(input logic [5:0] a);
        logic [15:0] k;
        av(1'b0, a, 32'h00000000, 4'hf, v, k);
    endtask
    task automatic edge_chk(input int s, input logic l, input logic [15:0] cnt, input logic [15:0] exp);
        pm.set_count(cnt);
        pm.set_pin(s, l);
        cyc(6);
        chk("o_capture", {16'h0000, exp}, {16'h0000, o_capture});
    endtask
    // main sequence
    initial begin
        logic [5:0] offs [10];
        logic [15:0] prev;
        int mark;
        offs = '{tic_pkg::OFF_MODE, tic_pkg::OFF_INT0, tic_pkg::OFF_INT1, tic_pkg::OFF_INT2,
                 tic_pkg::OFF_INT3, tic_pkg::OFF_DUAL, tic_pkg::OFF_CAP, tic_pkg::OFF_STAT,
                 tic_pkg::OFF_MASK, 6'h3c};
        cyc(5);
        i_nrst <= 1'b1;
        cyc(4);
        // reset values, unmapped word included
        foreach (offs[i]) begin
            rd(offs[i]);
            chk("reset readdata", 32'h00000000, v);
        end
        wr(6'h3c, 32'hffffffff);
        rd(6'h3c);
        chk("unmapped", 32'h00000000, v);
        chk("clear sel", 32'h0, {31'h0, o_counter_clear_sel});
        // edges ignored while external triggering is still off
        edge_chk(0, 1'b1, 16'h1234, 16'h0000);
        edge_chk(0, 1'b0, 16'h1235, 16'h0000);
        // software trigger on byte lanes 0 and 1 with a running counter
        pm.go();
        for (int b = 0; b < 2; b++) begin
            av(1'b1, tic_pkg::OFF_CAP, 32'h0000ffff, 4'h1 << b, v, c);
            cyc(2);
            chk("o_capture", {16'h0000, c}, {16'h0000, o_capture});
            rd(tic_pkg::OFF_CAP);
            chk("capture bytes", {16'h0000, c}, {16'h0000, v[15:8], v[7:0]});
        end
        // each source in single-edge and then both-edge mode
        for (int s = 0; s < 4; s++) begin
            wr(tic_pkg::OFF_INT0 + 6'(4 * s), 32'h00000020);
            wr(tic_pkg::OFF_MODE, 32'h00000084 | s);
            prev = 16'h1100 + 16'(s);
            edge_chk(s, 1'b1, prev, prev);
            cyc(8);
            chk("held level", {16'h0000, prev}, {16'h0000, o_capture});
            edge_chk((s + 1) % 4, 1'b1, 16'h2200, prev);
            edge_chk((s + 1) % 4, 1'b0, 16'h2201, prev);
            edge_chk(s, 1'b0, 16'h2202, prev);
            wr(tic_pkg::OFF_MODE, 32'h00000004 | s);
            edge_chk(s, 1'b1, 16'h3300 + 16'(s), 16'h3300 + 16'(s));
            edge_chk(s, 1'b0, 16'h4400 + 16'(s), 16'h4400 + 16'(s));
        end
        // dual-edge interrupt select exists for inputs 0 and 1 only
        wr(tic_pkg::OFF_DUAL, 32'h000000ff);
        rd(tic_pkg::OFF_DUAL);
        chk("dual sel", 32'h3, v & 32'hf);
        wr(tic_pkg::OFF_MODE, 32'h00000084);
        mark = req_seen;
        edge_chk(0, 1'b1, 16'h5500, 16'h5500);
        wr(tic_pkg::OFF_STAT, 32'h0000001f);
        edge_chk(0, 1'b0, 16'h5600, 16'h5500);
        rd(tic_pkg::OFF_STAT);
        chk("int0 on fall", 32'h2, v & 32'h3);
        edge_chk(2, 1'b1, 16'h5700, 16'h5500);
        wr(tic_pkg::OFF_STAT, 32'h0000001f);
        edge_chk(2, 1'b0, 16'h5800, 16'h5500);
        chk("o_ext_int_req", 32'h3, 32'(req_seen - mark));
        rd(tic_pkg::OFF_STAT);
        chk("int2 on fall", 32'h0, v & 32'h8);
        // polarity flip onto the live low level fires, the reverse flip does not
        wr(tic_pkg::OFF_DUAL, 32'h00000000);
        wr(tic_pkg::OFF_STAT, 32'h0000001f);
        pm.set_count(16'h6600);
        wr(tic_pkg::OFF_INT0, 32'h00000000);
        cyc(6);
        chk("o_capture", 32'h6600, {16'h0000, o_capture});
        rd(tic_pkg::OFF_STAT);
        chk("flip status", 32'h3, v & 32'h3);
        pm.set_count(16'h6700);
        wr(tic_pkg::OFF_INT0, 32'h00000020);
        cyc(6);
        chk("o_capture", 32'h6600, {16'h0000, o_capture});
        // interrupt line: masked, unmasked, then sticky bit cleared by one
        wr(tic_pkg::OFF_MASK, 32'h00000000);
        cyc(2);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        wr(tic_pkg::OFF_MASK, 32'h00000001);
        cyc(2);
        chk("irq raised", 32'h1, {31'h0, o_irq});
        wr(tic_pkg::OFF_STAT, 32'h00000001);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        rd(tic_pkg::OFF_STAT);
        chk("status w1c", 32'h2, v & 32'h3);
        // counter clear source select reaches the timer
        wr(tic_pkg::OFF_MODE, 32'h00000020);
        cyc(2);
        chk("clear sel", 32'h1, {31'h0, o_counter_clear_sel});
        results();
    end
endmodule
`default_nettype wire
